/* verilog/btsc_pkg.sv */
/*
  constants shared by the branch trace store control block: register indices,
  control field positions, reset values and record geometry.
  assumes a 64-bit register port indexed by a 4-bit register number.
*/
package btsc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned PRIV_W = 2;

  localparam logic [3:0] REG_DBG_CTL = 4'h0;
  localparam logic [3:0] REG_MISC_FEAT = 4'h1;
  localparam logic [3:0] REG_FEAT_ID = 4'h2;
  localparam logic [3:0] REG_DS_BASE = 4'h3;
  localparam logic [3:0] REG_BUF_BASE = 4'h4;
  localparam logic [3:0] REG_BUF_INDEX = 4'h5;
  localparam logic [3:0] REG_BUF_MAX = 4'h6;
  localparam logic [3:0] REG_BUF_THRESH = 4'h7;
  localparam logic [3:0] REG_LER_SRC = 4'h8;
  localparam logic [3:0] REG_LER_TGT = 4'h9;
  localparam logic [3:0] REG_IRQ_CAUSE = 4'ha;
  localparam logic [3:0] REG_IRQ_MASK = 4'hb;

  localparam int unsigned MSG_EN_BIT = 2;
  localparam int unsigned STORE_EN_BIT = 3;
  localparam int unsigned FULL_IRQ_EN_BIT = 4;
  localparam int unsigned SKIP_KERNEL_BIT = 5;
  localparam int unsigned SKIP_USER_BIT = 6;
  localparam int unsigned STORE_UNSUP_BIT = 0;
  localparam int unsigned DS_FEATURE_BIT = 21;

  localparam int unsigned CAUSE_STORE_BIT = 0;
  localparam int unsigned CAUSE_PRECISE_BIT = 1;
  localparam int unsigned CAUSE_NONPRECISE_BIT = 2;
  localparam int unsigned CAUSE_W = 3;

  localparam logic [63:0] REC_BYTES = 64'h0000_0000_0000_0010;
  localparam logic [63:0] ZERO64 = 64'h0;
  localparam logic [1:0] PRIV_KERNEL = 2'h0;
endpackage

/* verilog/btsc_route_if.sv */
/*
  carrier between the trace control core and its routing decoder.
  assumes the core drives control flags and privilege, the decoder the routing.
*/
`timescale 1ns/100ps
interface btsc_route_if;
  logic msg_en;
  logic store_en;
  logic full_irq_en;
  logic skip_kernel;
  logic skip_user;
  logic [1:0] priv;
  logic send_bus;
  logic store_rec;
  logic storing_active;
  logic circular;

  modport core (
    output msg_en, store_en, full_irq_en, skip_kernel, skip_user, priv,
    input send_bus, store_rec, storing_active, circular
  );
  modport dec (
    input msg_en, store_en, full_irq_en, skip_kernel, skip_user, priv,
    output send_bus, store_rec, storing_active, circular
  );
endinterface

/* verilog/btsc_route.sv */
/*
  routing decoder: turns the trace control flags and the current privilege
  into bus, store and wrap decisions. purely combinational.
  assumes the core samples its outputs on the branch event.
*/
`timescale 1ns/100ps
module btsc_route
  import btsc_pkg::*;
(
  btsc_route_if.dec rt
);
  logic priv_ok;

  always_comb begin
    // both skips set: nothing is stored, and no message is sent while store is enabled
    priv_ok = 1'b1;
    if (rt.skip_kernel && rt.skip_user) begin
      priv_ok = 1'b0; // R13
    end else if (rt.skip_kernel) begin
      priv_ok = (rt.priv != PRIV_KERNEL); // R11
    end else if (rt.skip_user) begin
      priv_ok = (rt.priv == PRIV_KERNEL); // R12
    end
  end

  always_comb begin
    rt.storing_active = rt.msg_en && rt.store_en; // R7
    rt.send_bus = rt.msg_en && !rt.store_en; // R8
    rt.store_rec = rt.storing_active && priv_ok; // R8
    rt.circular = !rt.full_irq_en; // R9
  end
endmodule

/* verilog/btsc_top.sv */
/*
  branch trace store control: last exception records, trace control flags,
  bus message path, buffered record store with wrap or threshold interrupt,
  shared performance interrupt with delivery mask.
  assumes synchronous inputs, one branch event per cycle at most and a memory
  write port that always accepts.
*/
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
// Overview of operation
// R1 - keep last-exception source/target pair of the branch before an exception
// R2 - records are 64 bits; only low 32 visible while extended mode off
// R3 - 64-bit submode stores full address; compatibility submode clears upper half
// R4 - identification register reports the debug store feature at bit 21
// R5 - store enable bits are writable only when store is supported
// R6 - software builds the buffer area and writes its base pointer first
// R7 - message enable clear means no branch messages at all
// R8 - store enable picks bus or buffer, never both
// R9 - full interrupt enable clear wraps circularly, set raises interrupt near full
// R10 - index at or above threshold makes the buffer an interrupt source
// R11 - skip kernel alone stores only records with privilege above zero
// R12 - skip user alone stores only records with privilege zero
// R13 - both skips set: messages generated, none stored; here no message is sent either while store is enabled
// R14 - a full non-circular buffer leaves the configuration enabled
// R15 - delivered interrupt masks further ones until software clears the mask
// R16 - buffer, precise and non-precise sampling share one interrupt output
// R17 - handler resets the buffer index to the buffer start after reading
// R18 - handler clears message and precise enables on entry, restores on exit
// R19 - handler clears the interrupt mask before completing service
// R20 - buffer base is doubleword aligned and linearly contiguous
// R21 - buffer addresses keep bit 20 zero unless bit-20 masking is prevented
// R22 - control bits: message 2, store 3, full irq 4, skip kernel 5, skip user 6
// R23 - index advances one record per write and wraps at the maximum
module btsc_top
  import btsc_pkg::*;
#(
  parameter bit STORE_SUPPORTED = 1'b1,
  parameter bit DS_SUPPORTED = 1'b1
)(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic ext_addr_en,
  input wire logic long64_submode,
  input wire logic br_valid,
  input wire logic br_is_exc,
  input wire logic [63:0] br_from,
  input wire logic [63:0] br_to,
  input wire logic [PRIV_W-1:0] br_priv,
  input wire logic precise_irq_req,
  input wire logic nonprecise_irq_req,
  output logic msg_valid,
  output logic [63:0] msg_from,
  output logic [63:0] msg_to,
  output logic mem_wr_valid,
  output logic [63:0] mem_wr_addr,
  output logic [127:0] mem_wr_data,
  output logic perf_monitor_irq
);
  logic [DATA_W-1:0] rdata_ff;
  logic msg_en_ff;
  logic store_en_ff;
  logic full_irq_en_ff;
  logic skip_kernel_ff;
  logic skip_user_ff;
  logic [63:0] ds_base_ff;
  logic [63:0] buf_base_ff;
  logic [63:0] buf_index_ff;
  logic [63:0] buf_max_ff;
  logic [63:0] buf_thresh_ff;
  logic [63:0] last_from_ff;
  logic [63:0] last_to_ff;
  logic [63:0] ler_src_ff;
  logic [63:0] ler_tgt_ff;
  logic [CAUSE_W-1:0] cause_ff;
  logic irq_masked_ff;
  logic irq_ff;
  logic msg_valid_ff;
  logic [63:0] msg_from_ff;
  logic [63:0] msg_to_ff;
  logic mem_wr_valid_ff;
  logic [63:0] mem_wr_addr_ff;
  logic [127:0] mem_wr_data_ff;

  logic wr_ctl;
  logic do_store;
  logic [63:0] nxt_index;
  logic [CAUSE_W-1:0] cause_set;
  logic [CAUSE_W-1:0] cause_clr;
  logic [CAUSE_W-1:0] nxt_cause;
  logic [63:0] ler_src_vis;
  logic [63:0] ler_tgt_vis;
  logic [63:0] nxt_rdata;

  btsc_route_if rt ();

  assign rt.msg_en = msg_en_ff;
  assign rt.store_en = store_en_ff;
  assign rt.full_irq_en = full_irq_en_ff;
  assign rt.skip_kernel = skip_kernel_ff;
  assign rt.skip_user = skip_user_ff;
  assign rt.priv = br_priv;

  btsc_route u_route (
    .rt(rt)
  );

  assign wr_ctl = reg_we && (reg_addr == REG_DBG_CTL);

  // control register; the store facility never switches itself off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      msg_en_ff <= 1'b0;
      store_en_ff <= 1'b0;
      full_irq_en_ff <= 1'b0;
      skip_kernel_ff <= 1'b0;
      skip_user_ff <= 1'b0;
    end else if (wr_ctl) begin
      msg_en_ff <= reg_wdata[MSG_EN_BIT]; // R22
      skip_kernel_ff <= reg_wdata[SKIP_KERNEL_BIT]; // R22
      skip_user_ff <= reg_wdata[SKIP_USER_BIT]; // R22
      if (STORE_SUPPORTED) begin
        store_en_ff <= reg_wdata[STORE_EN_BIT]; // R5
        full_irq_en_ff <= reg_wdata[FULL_IRQ_EN_BIT]; // R5
      end
    end
  end

  // buffer pointers; software owns them, hardware only moves the index
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ds_base_ff <= ZERO64;
      buf_base_ff <= ZERO64;
      buf_max_ff <= ZERO64;
      buf_thresh_ff <= ZERO64;
    end else if (reg_we) begin
      case (reg_addr)
        REG_DS_BASE: ds_base_ff <= reg_wdata;
        REG_BUF_BASE: buf_base_ff <= reg_wdata;
        REG_BUF_MAX: buf_max_ff <= reg_wdata;
        REG_BUF_THRESH: buf_thresh_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // a full non-circular buffer drops records but stays configured
  assign do_store = br_valid && rt.store_rec &&
                    (rt.circular || (buf_index_ff < buf_max_ff)); // R14

  always_comb begin
    nxt_index = buf_index_ff + REC_BYTES; // R23
    if (rt.circular && (nxt_index >= buf_max_ff)) begin
      nxt_index = buf_base_ff; // R23
    end
  end

  // a software index write wins so the handler rewind is never lost
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_index_ff <= ZERO64;
    end else if (reg_we && (reg_addr == REG_BUF_INDEX)) begin
      buf_index_ff <= reg_wdata;
    end else if (do_store) begin
      buf_index_ff <= nxt_index; // R23
    end
  end

  // record write towards memory
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_wr_valid_ff <= 1'b0;
      mem_wr_addr_ff <= ZERO64;
      mem_wr_data_ff <= {ZERO64, ZERO64};
    end else begin
      mem_wr_valid_ff <= do_store; // R8
      if (do_store) begin
        mem_wr_addr_ff <= buf_index_ff;
        mem_wr_data_ff <= {br_to, br_from};
      end
    end
  end

  // bus message path, exclusive with the store path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      msg_valid_ff <= 1'b0;
      msg_from_ff <= ZERO64;
      msg_to_ff <= ZERO64;
    end else begin
      msg_valid_ff <= br_valid && rt.send_bus; // R7
      if (br_valid && rt.send_bus) begin
        msg_from_ff <= br_from; // R8
        msg_to_ff <= br_to;
      end
    end
  end

  // last branch tracker and last exception pair
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_from_ff <= ZERO64;
      last_to_ff <= ZERO64;
      ler_src_ff <= ZERO64;
      ler_tgt_ff <= ZERO64;
    end else if (br_valid) begin
      last_from_ff <= br_from;
      last_to_ff <= br_to;
      if (br_is_exc) begin
        if (ext_addr_en && long64_submode) begin
          ler_src_ff <= last_from_ff; // R1
          ler_tgt_ff <= last_to_ff; // R1
        end else begin
          ler_src_ff <= {32'h0000_0000, last_from_ff[31:0]}; // R3
          ler_tgt_ff <= {32'h0000_0000, last_to_ff[31:0]}; // R3
        end
      end
    end
  end

  // upper half hidden, not cleared, while extended addressing is off
  assign ler_src_vis = ext_addr_en ? ler_src_ff : {32'h0000_0000, ler_src_ff[31:0]}; // R2
  assign ler_tgt_vis = ext_addr_en ? ler_tgt_ff : {32'h0000_0000, ler_tgt_ff[31:0]}; // R2

  // interrupt causes: sticky, write one to clear, a new event beats the clear
  always_comb begin
    cause_set = '0;
    cause_set[CAUSE_STORE_BIT] = rt.storing_active && full_irq_en_ff &&
                                 (buf_index_ff >= buf_thresh_ff); // R10
    cause_set[CAUSE_PRECISE_BIT] = precise_irq_req; // R16
    cause_set[CAUSE_NONPRECISE_BIT] = nonprecise_irq_req; // R16
    cause_clr = '0;
    if (reg_we && (reg_addr == REG_IRQ_CAUSE)) begin
      cause_clr = reg_wdata[CAUSE_W-1:0];
    end
    nxt_cause = (cause_ff & ~cause_clr) | cause_set;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_ff <= '0;
    end else begin
      cause_ff <= nxt_cause; // R9
    end
  end

  // one shared pulse per delivery, then masked until software clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
      irq_masked_ff <= 1'b0;
    end else begin
      irq_ff <= (|cause_ff) && !irq_masked_ff; // R16
      if ((|cause_ff) && !irq_masked_ff) begin
        irq_masked_ff <= 1'b1; // R15
      end else if (reg_we && (reg_addr == REG_IRQ_MASK) && reg_wdata[0]) begin
        irq_masked_ff <= 1'b0; // R15
      end
    end
  end

  // read mux; data stand only in the cycle after the strobe
  always_comb begin
    nxt_rdata = ZERO64;
    case (reg_addr)
      REG_DBG_CTL: begin
        nxt_rdata[MSG_EN_BIT] = msg_en_ff;
        nxt_rdata[STORE_EN_BIT] = store_en_ff;
        nxt_rdata[FULL_IRQ_EN_BIT] = full_irq_en_ff;
        nxt_rdata[SKIP_KERNEL_BIT] = skip_kernel_ff;
        nxt_rdata[SKIP_USER_BIT] = skip_user_ff;
      end
      REG_MISC_FEAT: nxt_rdata[STORE_UNSUP_BIT] = !STORE_SUPPORTED; // R5
      REG_FEAT_ID: nxt_rdata[DS_FEATURE_BIT] = DS_SUPPORTED; // R4
      REG_DS_BASE: nxt_rdata = ds_base_ff;
      REG_BUF_BASE: nxt_rdata = buf_base_ff;
      REG_BUF_INDEX: nxt_rdata = buf_index_ff;
      REG_BUF_MAX: nxt_rdata = buf_max_ff;
      REG_BUF_THRESH: nxt_rdata = buf_thresh_ff;
      REG_LER_SRC: nxt_rdata = ler_src_vis;
      REG_LER_TGT: nxt_rdata = ler_tgt_vis;
      REG_IRQ_CAUSE: nxt_rdata[CAUSE_W-1:0] = cause_ff;
      REG_IRQ_MASK: nxt_rdata[0] = irq_masked_ff;
      default: nxt_rdata = ZERO64;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= ZERO64;
    end else if (reg_re) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= ZERO64;
    end
  end

  assign reg_rdata = rdata_ff;
  assign msg_valid = msg_valid_ff;
  assign msg_from = msg_from_ff;
  assign msg_to = msg_to_ff;
  assign mem_wr_valid = mem_wr_valid_ff;
  assign mem_wr_addr = mem_wr_addr_ff;
  assign mem_wr_data = mem_wr_data_ff;
  assign perf_monitor_irq = irq_ff;
endmodule

/* tb/btsc_checker.sv */
/*
  checker: port-level timing and routing relations of the trace store control block.
  assumes binding into btsc_top with the default store support.
*/
`timescale 1ns/100ps
module btsc_checker
  import btsc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic br_valid,
  input wire logic [PRIV_W-1:0] br_priv,
  input wire logic msg_valid,
  input wire logic mem_wr_valid,
  input wire logic perf_monitor_irq
);
  logic [6:0] ctl_ff;

  // shadow of the control flags, so routing can be judged without the bodies
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_ff <= 7'h00;
    end else if (reg_we && reg_addr == REG_DBG_CTL) begin
      ctl_ff <= reg_wdata[6:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_dest_exclusive: assert property (!(msg_valid && mem_wr_valid))
    else $error("message and store in one cycle");
  a_msg_cause: assert property (msg_valid |-> $past(br_valid) && $past(ctl_ff[2]))
    else $error("message without enabled event");
  a_store_cause: assert property (mem_wr_valid |-> $past(br_valid) && $past(ctl_ff[3]))
    else $error("store without enabled event");
  a_bus_route: assert property (br_valid && ctl_ff[2] && !ctl_ff[3] |=> msg_valid)
    else $error("bus message missing");
  a_off_silent: assert property (br_valid && !ctl_ff[2] |=> !msg_valid && !mem_wr_valid)
    else $error("output while messages off");
  a_kernel_skip: assert property (br_valid && ctl_ff[6:5] == 2'h1 && br_priv == PRIV_KERNEL
    |=> !mem_wr_valid)
    else $error("kernel record stored");
  a_user_skip: assert property (br_valid && ctl_ff[6:5] == 2'h2 && br_priv != PRIV_KERNEL
    |=> !mem_wr_valid)
    else $error("user record stored");
  a_skip_both: assert property (br_valid && ctl_ff[6:5] == 2'h3 |=> !mem_wr_valid)
    else $error("record stored with both skips");
  a_irq_single: assert property (perf_monitor_irq |=> !perf_monitor_irq)
    else $error("interrupt not masked after delivery");
endmodule

bind btsc_top btsc_checker btsc_checker_i (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_we,
  .br_valid, .br_priv, .msg_valid, .mem_wr_valid, .perf_monitor_irq);

/* tb/btsc_mem_model.sv */
/*
  far side model: system bus monitor and memory buffer write port.
  assumes writes are always taken, as the block has no back-pressure.
*/
`timescale 1ns/100ps
module btsc_mem_model (
  input wire logic clk,
  input wire logic msg_valid,
  input wire logic [63:0] msg_from,
  input wire logic [63:0] msg_to,
  input wire logic mem_wr_valid,
  input wire logic [63:0] mem_wr_addr,
  input wire logic [127:0] mem_wr_data,
  output logic [63:0] last_addr,
  output logic [127:0] last_data,
  output logic [127:0] last_msg
);
  always_ff @(posedge clk) begin
    if (mem_wr_valid) begin
      last_addr <= mem_wr_addr;
      last_data <= mem_wr_data;
    end
    if (msg_valid) begin
      last_msg <= {msg_to, msg_from};
    end
  end
endmodule

/* tb/tb_branch_trace_store_control.sv */
/*
  testbench: register, branch event and interrupt sequences with expected values.
  assumes btsc_top defaults, store and debug store supported.
*/
`timescale 1ns/100ps
module tb_branch_trace_store_control
  import btsc_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, reg_we = 1'b0, reg_re = 1'b0, br_valid = 1'b0;
  logic br_is_exc = 1'b0, ext_addr_en = 1'b0, long64_submode = 1'b0;
  logic precise_irq_req = 1'b0, nonprecise_irq_req = 1'b0;
  logic msg_valid, mem_wr_valid, perf_monitor_irq;
  logic [3:0] reg_addr = 4'h0;
  logic [1:0] br_priv = 2'h0;
  logic [63:0] reg_wdata = 64'h0, br_from = 64'h0, br_to = 64'h0;
  logic [63:0] reg_rdata, msg_from, msg_to, mem_wr_addr, last_addr;
  logic [127:0] mem_wr_data, last_data, last_msg;
  int fails = 0, n_compared = 0, i;

  btsc_top btsc_top_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .ext_addr_en(ext_addr_en), .long64_submode(long64_submode), .br_valid(br_valid),
    .br_is_exc(br_is_exc), .br_from(br_from), .br_to(br_to), .br_priv(br_priv),
    .precise_irq_req(precise_irq_req), .nonprecise_irq_req(nonprecise_irq_req),
    .msg_valid(msg_valid), .msg_from(msg_from), .msg_to(msg_to),
    .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .perf_monitor_irq(perf_monitor_irq));
  btsc_mem_model btsc_mem_model_i (.clk(clk), .msg_valid(msg_valid), .msg_from(msg_from),
    .msg_to(msg_to), .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .last_addr(last_addr), .last_data(last_data),
    .last_msg(last_msg));

  task results;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic [191:0] got, input logic [191:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [63:0] e);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // m selects which of {message, store} is judged, k is the expected pair
  task ev(input logic [63:0] f, t, input logic [1:0] p, input logic x, input logic [1:0] m, k);
    @(posedge clk);
    br_valid <= 1'b1;
    br_from <= f;
    br_to <= t;
    br_priv <= p;
    br_is_exc <= x;
    @(posedge clk);
    br_valid <= 1'b0;
    br_is_exc <= 1'b0;
    #1 chk({msg_valid, mem_wr_valid} & m, k);
  endtask
  task irq_wait(input logic e);
    int n;
    n = 0;
    #1;
    while (perf_monitor_irq !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(perf_monitor_irq, e);
  endtask

  initial forever #5 clk = ~clk;
  // the whole sequence needs well under 1000 cycles
  initial begin
    #20000;
    fails++;
    results;
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd(REG_FEAT_ID, 64'h20_0000);
    wr(REG_FEAT_ID, 64'h0);
    rd(REG_FEAT_ID, 64'h20_0000);
    rd(REG_MISC_FEAT, 64'h0);
    rd(4'hf, 64'h0);
    ev(64'h10, 64'h20, 2'h0, 1'b0, 2'h3, 2'h0);
    wr(REG_DS_BASE, 64'h1000);
    wr(REG_BUF_BASE, 64'h2000);
    wr(REG_BUF_MAX, 64'h2040);
    wr(REG_BUF_THRESH, 64'h2030);
    wr(REG_BUF_INDEX, 64'h2000);
    wr(REG_DBG_CTL, 64'h4);
    ev(64'h11, 64'h21, 2'h3, 1'b0, 2'h3, 2'h2);
    @(posedge clk);
    #1 chk(last_msg, {64'h21, 64'h11});
    wr(REG_DBG_CTL, 64'hc);
    rd(REG_DBG_CTL, 64'hc);
    for (i = 0; i < 4; i++) begin
      ev(64'h100 + i, 64'h200 + i, 2'h1, 1'b0, 2'h3, 2'h1);
      @(posedge clk);
      #1 chk({last_addr, last_data}, {64'h2000 + 16 * i, 64'h200 + i, 64'h100 + i});
    end
    rd(REG_BUF_INDEX, 64'h2000);
    wr(REG_DBG_CTL, 64'h2c);
    ev(64'h1, 64'h2, 2'h0, 1'b0, 2'h1, 2'h0);
    ev(64'h1, 64'h2, 2'h3, 1'b0, 2'h1, 2'h1);
    wr(REG_DBG_CTL, 64'h4c);
    ev(64'h1, 64'h2, 2'h0, 1'b0, 2'h1, 2'h1);
    ev(64'h1, 64'h2, 2'h2, 1'b0, 2'h1, 2'h0);
    wr(REG_DBG_CTL, 64'h7c);
    ev(64'h1, 64'h2, 2'h0, 1'b0, 2'h1, 2'h0);
    ev(64'h1, 64'h2, 2'h1, 1'b0, 2'h1, 2'h0);
    wr(REG_DBG_CTL, 64'h1c);
    ev(64'h1, 64'h2, 2'h0, 1'b0, 2'h3, 2'h1);
    irq_wait(1'b1);
    rd(REG_IRQ_CAUSE, 64'h1);
    rd(REG_IRQ_MASK, 64'h1);
    ev(64'h1, 64'h2, 2'h0, 1'b0, 2'h3, 2'h1);
    irq_wait(1'b0);
    ev(64'h1, 64'h2, 2'h0, 1'b0, 2'h3, 2'h0);
    rd(REG_DBG_CTL, 64'h1c);
    wr(REG_DBG_CTL, 64'h18);
    wr(REG_BUF_INDEX, 64'h2000);
    wr(REG_IRQ_CAUSE, 64'h1);
    wr(REG_IRQ_MASK, 64'h1);
    rd(REG_IRQ_CAUSE, 64'h0);
    wr(REG_DBG_CTL, 64'h1c);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      precise_irq_req <= (i == 0);
      nonprecise_irq_req <= (i == 1);
      @(posedge clk);
      precise_irq_req <= 1'b0;
      nonprecise_irq_req <= 1'b0;
      irq_wait(1'b1);
      rd(REG_IRQ_CAUSE, 64'h2 << i);
      wr(REG_IRQ_CAUSE, 64'h6);
      wr(REG_IRQ_MASK, 64'h1);
    end
    wr(REG_DBG_CTL, 64'h0);
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      ext_addr_en <= (i < 2);
      long64_submode <= (i == 0);
      ev(64'hf000_0000_0000_0100 + i, 64'he000_0000_0000_0200 + i, 2'h0, 1'b0,
        2'h3, 2'h0);
      ev(64'h5, 64'h6, 2'h0, 1'b1, 2'h3, 2'h0);
      rd(REG_LER_SRC, (i == 0 ? 64'hf000_0000_0000_0000 : 64'h0) + 64'h100 + i);
      rd(REG_LER_TGT, (i == 0 ? 64'he000_0000_0000_0000 : 64'h0) + 64'h200 + i);
    end
    // upper half must survive a spell with extended addressing off
    @(posedge clk);
    ext_addr_en <= 1'b1;
    long64_submode <= 1'b1;
    ev(64'hd000_0000_0000_0300, 64'hc000_0000_0000_0400, 2'h0, 1'b0, 2'h3, 2'h0);
    ev(64'h7, 64'h8, 2'h0, 1'b1, 2'h3, 2'h0);
    @(posedge clk);
    ext_addr_en <= 1'b0;
    rd(REG_LER_SRC, 64'h300);
    @(posedge clk);
    ext_addr_en <= 1'b1;
    rd(REG_LER_SRC, 64'hd000_0000_0000_0300);
    // a second reset in mid-run must bring the records and the index back to zero
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rd(REG_LER_SRC, 64'h0);
    rd(REG_BUF_INDEX, 64'h0);
    results;
  end
endmodule
